// ==== inc/tpu_pkg.sv ====
// Package: register map, field layout and modes of the timer/PWM core
package tpu_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] BLOCK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] COUNTER_CONTROL_OFS = 8'h04;
  localparam logic [7:0] TRIGGER_SELECT_OFS = 8'h08;
  localparam logic [7:0] TRIGGER_EDGE_OFS = 8'h0C;
  localparam logic [7:0] COMMAND_OFS = 8'h10;
  localparam logic [7:0] COUNT_OFS = 8'h14;
  localparam logic [7:0] COMPARE_OFS = 8'h18;
  localparam logic [7:0] COMPARE_BUF_OFS = 8'h1C;
  localparam logic [7:0] PERIOD_OFS = 8'h20;
  localparam logic [7:0] PERIOD_BUF_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  // ==========================================================
  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int PRESCALE_LSB = 8;
  localparam int DIRECTION_LSB = 16;
  localparam int MODE_LSB = 24;
  localparam int SELECT_WIDTH = 4;
  localparam int EDGE_WIDTH = 2;
  localparam int NUM_EVENTS = 5;
  localparam int NUM_SOURCES = 16;
  localparam int NUM_PINS = 8;
  localparam int NUM_LOW_POWER_COMPARATOR = 2;
  localparam int COUNT_WIDTH = 16;
  localparam int DIV_WIDTH = 7;
  localparam int HOLD_CYCLES = 2;
  // Event indices in command, select and edge fields
  localparam int EV_RELOAD = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  localparam int EV_COUNT = 3;
  localparam int EV_CAPTURE = 4;
  // ==========================================================
  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [19:0] SELECT_RESET = 20'h00000;
  localparam logic [9:0] EDGE_RESET = 10'h000;
  localparam logic [6:0] DIV_ONES = 7'h7F;
  // ==========================================================
  // Operating modes, counting directions, trigger detection
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_QUAD = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_PWM_DEAD_TIME_MODE = 3'h5;
  localparam logic [2:0] MODE_PWM_PR = 3'h6;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_UPDOWN = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_LEVEL = 2'h3;
endpackage

// ==== logic/tpu_trig_detect.sv ====
// Module: edge or level detection of one event trigger
`timescale 1ns/10ps
`default_nettype none
module tpu_trig_detect (
  // System
  input wire logic mclk,
  input wire logic nrst,
  // Trigger level, already synchronised, and its detect mode
  input wire logic level,
  input wire logic [1:0] edge_mode,
  // Firmware request pulse
  input wire logic sw_req,
  // Detected event
  output logic event_out
);
  logic prev;
  logic next_prev;
  logic hw_hit;

  // ==========================================================
  // Detector: compare with last cycle's level
  always_comb begin
    next_prev = level;
    unique case (edge_mode)
      tpu_pkg::EDGE_RISE: hw_hit = level & ~prev;
      tpu_pkg::EDGE_FALL: hw_hit = ~level & prev;
      tpu_pkg::EDGE_BOTH: hw_hit = level ^ prev;
      tpu_pkg::EDGE_LEVEL: hw_hit = level;
    endcase
    event_out = hw_hit | sw_req;
  end

  // Previous level register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule // tpu_trig_detect
`default_nettype wire

// ==== logic/tpu_core.sv ====
// Module: 16-bit timer/counter/PWM core with Wishbone registers
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Enable bit 0 of block control starts the counter; here it only gates the counter clock, reload or start sets running.
// - Disabled counter keeps all register values unchanged.
// - Counter clock is the system clock qualified by counter enable.
// - Prescale field bits 10:8 divide counter clock by 1 to 128.
// - No prescaling in quadrature or dead-time PWM modes.
// - Each event detects rising, falling, both edges or level.
// - Command register writes raise the same events from firmware.
// - Triggers select pins, peer counter signals or comparators.
// - Reload in up or up/down loads zero and starts.
// - Reload in down mode loads period and starts.
// - In quadrature mode reload is the index event.
// - Start resumes from current count without initialising.
// - Quadrature uses start as second phase, count as first.
// - Count event steps counter by one in configured direction.
// - Stop halts counting until a later start.
// - In PWM modes stop is a kill disabling PWM lines.
// - Capture copies count to capture, capture to buffer.
// - Overflow when counting up and count reaches period.
// - Underflow when counting down and count reaches zero.
// - Compare match or capture while running gives capture/compare.
// - Each condition output stays high two clock cycles.
// - PWM capture swaps compare and period with buffers.
// - All trigger inputs synchronised before detection.
module tpu_core (
  // System
  input wire logic mclk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  // Trigger sources
  input wire logic [7:0] trig_pin,
  input wire logic [1:0] low_power_comparator,
  input wire logic peer_overflow,
  input wire logic peer_underflow,
  input wire logic peer_cc,
  // Condition outputs and PWM kill
  output logic overflow_condition,
  output logic underflow_condition,
  output logic capture_compare_condition,
  output logic pwm_kill
);
  // ==========================================================
  // Declarations
  logic enable, next_enable;
  logic [2:0] prescale_field, next_prescale_field;
  logic [1:0] direction, next_direction;
  logic [2:0] mode, next_mode;
  logic [19:0] trig_select, next_trig_select;
  logic [9:0] trig_edge, next_trig_edge;
  logic [4:0] cmd_pulse, next_cmd_pulse;
  logic [15:0] count_reg, next_count_reg;
  logic [15:0] compare, next_compare;
  logic [15:0] compare_buf, next_compare_buf;
  logic [15:0] period_reg, next_period_reg;
  logic [15:0] period_buf, next_period_buf;
  logic running, next_running;
  logic count_down, next_count_down;
  logic next_pwm_kill;
  logic [4:0] pend, next_pend;
  logic [6:0] div, next_div;
  logic quad_a_prev, quad_b_prev;
  logic ov_hold, un_hold, cc_hold;
  logic ov_pulse, un_pulse, cc_pulse;
  logic next_ack;
  logic [31:0] next_dat_o;
  logic [15:0] sync1, sync2, sources;
  logic [4:0] levels, events, evt;
  logic counter_en, tick, wr_stb, pwm_mode, no_prescale;
  logic [6:0] div_mask;
  logic quad_a, quad_b;

  // Byte-lane merge of a write into an old register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Trigger source vector; 0 and 1 are constant choices
  assign sources = {1'b0, peer_cc, peer_underflow, peer_overflow,
                    low_power_comparator, trig_pin, 1'b1, 1'b0};

  // Two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else begin
      sync1 <= sources;
      sync2 <= sync1;
    end
  end

  // ==========================================================
  // Per-event source mux and detector
  genvar g;
  generate
    for (g = 0; g < tpu_pkg::NUM_EVENTS; g++) begin : gen_trig
      assign levels[g] =
        sync2[trig_select[g*tpu_pkg::SELECT_WIDTH +: tpu_pkg::SELECT_WIDTH]];
      tpu_trig_detect u_detect (
        .mclk(mclk),
        .nrst(nrst),
        .level(levels[g]),
        .edge_mode(trig_edge[g*tpu_pkg::EDGE_WIDTH +: tpu_pkg::EDGE_WIDTH]),
        .sw_req(cmd_pulse[g]),
        .event_out(events[g])
      );
    end
  endgenerate

  // ==========================================================
  // Counter clock: enable qualifies every clock, prescaler thins it
  assign counter_en = enable;
  assign pwm_mode = (mode == tpu_pkg::MODE_PWM) ||
                    (mode == tpu_pkg::MODE_PWM_DEAD_TIME_MODE) ||
                    (mode == tpu_pkg::MODE_PWM_PR);
  assign no_prescale = (mode == tpu_pkg::MODE_QUAD) ||
                       (mode == tpu_pkg::MODE_PWM_DEAD_TIME_MODE);
  assign div_mask = 7'(8'((8'h01 << prescale_field) - 8'h01));
  assign tick = counter_en && (no_prescale || ((div & div_mask) == div_mask));
  assign wr_stb = wb_cyc && wb_stb && wb_we && !wb_ack;
  assign quad_a = levels[tpu_pkg::EV_COUNT];
  assign quad_b = levels[tpu_pkg::EV_START];
  // Events that arrive between ticks wait; a tick consumes them
  assign evt = pend | events;

  // ==========================================================
  // Next state of counter, buffers, status and bus registers
  always_comb begin
    next_enable = enable;
    next_prescale_field = prescale_field;
    next_direction = direction;
    next_mode = mode;
    next_trig_select = trig_select;
    next_trig_edge = trig_edge;
    next_cmd_pulse = 5'h00;
    next_count_reg = count_reg;
    next_compare = compare;
    next_compare_buf = compare_buf;
    next_period_reg = period_reg;
    next_period_buf = period_buf;
    next_running = running;
    next_count_down = count_down;
    next_pwm_kill = pwm_kill;
    next_div = counter_en ? div + 7'h01 : 7'h00;
    // Disabled: pending events dropped, prescaler div cleared, counter state holds
    next_pend = counter_en ? (tick ? 5'h00 : evt) : 5'h00;
    ov_pulse = 1'b0;
    un_pulse = 1'b0;
    cc_pulse = 1'b0;
    next_ack = wb_cyc && wb_stb && !wb_ack;
    next_dat_o = 32'h00000000;

    if (tick && mode == tpu_pkg::MODE_QUAD) begin
      // Index resynchronises; phases step every clock
      if (evt[tpu_pkg::EV_RELOAD]) begin
        next_count_reg = 16'h0000;
        next_running = 1'b1;
      end else if ((quad_a ^ quad_a_prev) ^ (quad_b ^ quad_b_prev)) begin
        if (quad_a ^ quad_b_prev) begin
          next_count_reg = count_reg + 16'h0001;
        end else begin
          next_count_reg = count_reg - 16'h0001;
        end
      end
    end else if (tick) begin
      if (evt[tpu_pkg::EV_RELOAD]) begin
        next_running = 1'b1;
        next_pwm_kill = 1'b0;
        next_count_down = (direction == tpu_pkg::DIR_DOWN);
        if (direction == tpu_pkg::DIR_DOWN) begin
          next_count_reg = period_reg;
        end else begin
          next_count_reg = 16'h0000;
        end
      end else if (evt[tpu_pkg::EV_STOP]) begin
        next_running = 1'b0;
        next_pwm_kill = pwm_mode;
      end else if (evt[tpu_pkg::EV_START]) begin
        next_running = 1'b1;
        next_pwm_kill = 1'b0;
      end else if (evt[tpu_pkg::EV_COUNT] && running) begin
        // Wrap at period and zero; up/down mode turns around there
        if (!count_down) begin
          if (count_reg == period_reg) begin
            ov_pulse = 1'b1;
            if (direction == tpu_pkg::DIR_UPDOWN) begin
              next_count_down = 1'b1;
              next_count_reg = count_reg - 16'h0001;
            end else begin
              next_count_reg = 16'h0000;
            end
          end else begin
            next_count_reg = count_reg + 16'h0001;
          end
        end else begin
          if (count_reg == 16'h0000) begin
            un_pulse = 1'b1;
            if (direction == tpu_pkg::DIR_UPDOWN) begin
              next_count_down = 1'b0;
              next_count_reg = 16'h0001;
            end else begin
              next_count_reg = period_reg;
            end
          end else begin
            next_count_reg = count_reg - 16'h0001;
          end
        end
        if (next_count_reg == compare) begin
          cc_pulse = 1'b1;
        end
      end
    end
    // Capture acts in every mode, quadrature included
    if (tick && evt[tpu_pkg::EV_CAPTURE]) begin
      if (pwm_mode) begin
        next_compare = compare_buf;
        next_compare_buf = compare;
        next_period_reg = period_buf;
        next_period_buf = period_reg;
      end else begin
        next_compare = count_reg;
        next_compare_buf = compare;
        cc_pulse = cc_pulse | running;
      end
    end

    // Bus write; software reconfiguration wins over events
    if (wr_stb) begin
      unique case (wb_adr)
        tpu_pkg::BLOCK_CONTROL_OFS: begin
          if (wb_sel[0]) begin
            next_enable = wb_dat_i[tpu_pkg::ENABLE_BIT];
          end
        end
        tpu_pkg::COUNTER_CONTROL_OFS: begin
          if (wb_sel[1]) begin
            next_prescale_field = wb_dat_i[tpu_pkg::PRESCALE_LSB +: 3];
          end
          if (wb_sel[2]) begin
            next_direction = wb_dat_i[tpu_pkg::DIRECTION_LSB +: 2];
          end
          if (wb_sel[3]) begin
            next_mode = wb_dat_i[tpu_pkg::MODE_LSB +: 3];
          end
        end
        tpu_pkg::TRIGGER_SELECT_OFS: begin
          next_trig_select = 20'(merge({12'h000, trig_select},
                                       wb_dat_i, wb_sel));
        end
        tpu_pkg::TRIGGER_EDGE_OFS: begin
          next_trig_edge = 10'(merge({22'h000000, trig_edge},
                                     wb_dat_i, wb_sel));
        end
        tpu_pkg::COMMAND_OFS: begin
          if (wb_sel[0]) begin
            next_cmd_pulse = wb_dat_i[4:0];
          end
        end
        tpu_pkg::COUNT_OFS: begin
          next_count_reg = 16'(merge({16'h0000, count_reg}, wb_dat_i, wb_sel));
        end
        tpu_pkg::COMPARE_OFS: begin
          next_compare = 16'(merge({16'h0000, compare}, wb_dat_i, wb_sel));
        end
        tpu_pkg::COMPARE_BUF_OFS: begin
          next_compare_buf = 16'(merge({16'h0000, compare_buf},
                                       wb_dat_i, wb_sel));
        end
        tpu_pkg::PERIOD_OFS: begin
          next_period_reg = 16'(merge({16'h0000, period_reg},
                                      wb_dat_i, wb_sel));
        end
        tpu_pkg::PERIOD_BUF_OFS: begin
          next_period_buf = 16'(merge({16'h0000, period_buf},
                                      wb_dat_i, wb_sel));
        end
        default: begin
        end
      endcase
    end

    // Read data; unmapped addresses answer zero
    if (wb_cyc && wb_stb && !wb_we && !wb_ack) begin
      unique case (wb_adr)
        tpu_pkg::BLOCK_CONTROL_OFS: next_dat_o = {31'h00000000, enable};
        tpu_pkg::COUNTER_CONTROL_OFS:
          next_dat_o = {5'h00, mode, 6'h00, direction, 5'h00,
                        prescale_field, 8'h00};
        tpu_pkg::TRIGGER_SELECT_OFS: next_dat_o = {12'h000, trig_select};
        tpu_pkg::TRIGGER_EDGE_OFS: next_dat_o = {22'h000000, trig_edge};
        tpu_pkg::COUNT_OFS: next_dat_o = {16'h0000, count_reg};
        tpu_pkg::COMPARE_OFS: next_dat_o = {16'h0000, compare};
        tpu_pkg::COMPARE_BUF_OFS: next_dat_o = {16'h0000, compare_buf};
        tpu_pkg::PERIOD_OFS: next_dat_o = {16'h0000, period_reg};
        tpu_pkg::PERIOD_BUF_OFS: next_dat_o = {16'h0000, period_buf};
        tpu_pkg::STATUS_OFS:
          next_dat_o = {29'h00000000, pwm_kill, count_down, running};
        default: next_dat_o = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable <= 1'b0;
      prescale_field <= 3'h0;
      direction <= tpu_pkg::DIR_UP;
      mode <= tpu_pkg::MODE_TIMER;
      trig_select <= tpu_pkg::SELECT_RESET;
      trig_edge <= tpu_pkg::EDGE_RESET;
      cmd_pulse <= 5'h00;
      count_reg <= tpu_pkg::COUNT_RESET;
      compare <= tpu_pkg::COMPARE_RESET;
      compare_buf <= tpu_pkg::COMPARE_RESET;
      period_reg <= tpu_pkg::PERIOD_RESET;
      period_buf <= tpu_pkg::PERIOD_RESET;
      running <= 1'b0;
      count_down <= 1'b0;
      pwm_kill <= 1'b0;
      pend <= 5'h00;
      div <= 7'h00;
      quad_a_prev <= 1'b0;
      quad_b_prev <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      enable <= next_enable;
      prescale_field <= next_prescale_field;
      direction <= next_direction;
      mode <= next_mode;
      trig_select <= next_trig_select;
      trig_edge <= next_trig_edge;
      cmd_pulse <= next_cmd_pulse;
      count_reg <= next_count_reg;
      compare <= next_compare;
      compare_buf <= next_compare_buf;
      period_reg <= next_period_reg;
      period_buf <= next_period_buf;
      running <= next_running;
      count_down <= next_count_down;
      pwm_kill <= next_pwm_kill;
      pend <= next_pend;
      div <= next_div;
      quad_a_prev <= quad_a;
      quad_b_prev <= quad_b;
      wb_ack <= next_ack;
      wb_dat_o <= next_dat_o;
    end
  end

  // ==========================================================
  // Condition stretchers: a one-cycle pulse shows for two clocks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ov_hold <= 1'b0;
      un_hold <= 1'b0;
      cc_hold <= 1'b0;
      overflow_condition <= 1'b0;
      underflow_condition <= 1'b0;
      capture_compare_condition <= 1'b0;
    end else begin
      ov_hold <= ov_pulse;
      un_hold <= un_pulse;
      cc_hold <= cc_pulse;
      overflow_condition <= ov_pulse | ov_hold;
      underflow_condition <= un_pulse | un_hold;
      capture_compare_condition <= cc_pulse | cc_hold;
    end
  end

  // ==========================================================
  // Assertions and covers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  a_ov_two_cycles: assert property (
    ov_pulse |=> overflow_condition ##1 overflow_condition)
    else $error("overflow not held two cycles");
  a_un_two_cycles: assert property (
    un_pulse |=> underflow_condition ##1 underflow_condition)
    else $error("underflow not held two cycles");
  a_ov_at_period: assert property (
    ov_pulse |-> (count_reg == period_reg) && !count_down)
    else $error("overflow without period match");
  a_hold_disabled: assert property (
    (!enable && !wr_stb) |=> $stable(count_reg) && $stable(running))
    else $error("counter changed while disabled");
  a_reload_up_zero: assert property (
    (tick && evt[0] && !wr_stb && mode != tpu_pkg::MODE_QUAD &&
     direction != tpu_pkg::DIR_DOWN) |=> count_reg == 16'h0000 && running)
    else $error("reload did not clear counter");
  a_reload_down_per: assert property (
    (tick && evt[0] && !wr_stb && mode != tpu_pkg::MODE_QUAD &&
     direction == tpu_pkg::DIR_DOWN) |=> count_reg == $past(period_reg))
    else $error("reload did not load period");
  a_capture_copy: assert property (
    (tick && evt[4] && !pwm_mode && !wr_stb) |=>
      compare == $past(count_reg) && compare_buf == $past(compare))
    else $error("capture copy wrong");
  a_stop_halts: assert property (
    (tick && evt[2] && !evt[0] && !wr_stb &&
     mode != tpu_pkg::MODE_QUAD) |=> !running ##1 $stable(count_reg))
    else $error("stop did not halt counter");
  a_no_prescale: assert property (
    (enable && mode == tpu_pkg::MODE_QUAD) |-> tick)
    else $error("prescaler active in quadrature mode");

  c_overflow: cover property (ov_pulse ##2 !overflow_condition);
  c_capture: cover property (tick && evt[4] && running);
  c_kill: cover property ($rose(pwm_kill));
  c_underflow: cover property (un_pulse ##2 !underflow_condition);
endmodule // tpu_core
`default_nettype wire

// ==== dv/tpu_trig_src.sv ====
// Partner: trigger sources facing the timer/PWM core
`timescale 1ns/10ps
`default_nettype none
module tpu_trig_src (
  // Clock and request from the bench
  input wire logic mclk,
  input wire logic fire,
  // Trigger source levels
  output logic [7:0] trig_pin,
  output logic [1:0] low_power_comparator,
  output logic peer_overflow,
  output logic peer_underflow,
  output logic peer_cc
);
  logic [3:0] hold = 4'h0;
  // ==========================================================
  // Pin 0 pulse, held 8 cycles so it toggles well below mclk/4
  always @(posedge mclk) begin
    if (fire) hold <= 4'h8;
    else if (hold != 4'h0) hold <= hold - 4'h1;
  end
  assign trig_pin = {7'h00, hold != 4'h0};
  // Idle sources stay low
  assign low_power_comparator = 2'h0;
  assign peer_overflow = 1'b0;
  assign peer_underflow = 1'b0;
  assign peer_cc = 1'b0;
endmodule // tpu_trig_src
`default_nettype wire

// ==== dv/tpu_core_tb.sv ====
// Bench: self-checking test of the timer/PWM core
`timescale 1ns/10ps
`default_nettype none
module tpu_core_tb;
  // ==========================================================
  // Nets
  logic mclk = 1'b0, nrst = 1'b0, fire = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00, trig_pin;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, a, b, c;
  logic [1:0] lpc;
  logic pov, pun, pcc, ovf, unf, ccc, kill;
  logic [2:0] cond;
  int n_mismatch = 0, checked = 0;
  assign cond = {ccc, unf, ovf};
  always #2 mclk = ~mclk;
  tpu_trig_src src (.mclk(mclk), .fire(fire), .trig_pin(trig_pin),
    .low_power_comparator(lpc), .peer_overflow(pov),
    .peer_underflow(pun), .peer_cc(pcc));
  tpu_core dut (.mclk(mclk), .nrst(nrst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
    .trig_pin(trig_pin), .low_power_comparator(lpc),
    .peer_overflow(pov), .peer_underflow(pun), .peer_cc(pcc),
    .overflow_condition(ovf), .underflow_condition(unf),
    .capture_compare_condition(ccc), .pwm_kill(kill));
  // ==========================================================
  // Wishbone classic cycle; read data taken at the ack edge
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= ad;
    wb_sel <= 4'hF;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task rd(input logic [7:0] ad, output logic [31:0] q);
    bus(1'b0, ad, 32'h0, q);
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Length in cycles of the next pulse on one condition output
  task pulse(input int i);
    int n;
    n = 0;
    for (int k = 0; k < 300 && cond[i] !== 1'b1; k++) @(posedge mclk);
    while (cond[i] === 1'b1 && n < 9) begin
      n++;
      @(posedge mclk);
    end
    chk(32'h2, n);
  endtask
  // Pin 0 pulse from the partner, then time to land
  task pin();
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset();
    rd(tpu_pkg::PERIOD_OFS, a);
    chk(32'hFFFF, a);
    rd(tpu_pkg::STATUS_OFS, a);
    chk(32'h0, a);
    rd(8'h3C, a);
    chk(32'h0, a);
    $display("test reset done");
  endtask
  task t_up();
    wr(tpu_pkg::TRIGGER_EDGE_OFS, 32'hC0);
    wr(tpu_pkg::PERIOD_OFS, 32'h3);
    wr(tpu_pkg::COUNT_OFS, 32'h5);
    wr(tpu_pkg::BLOCK_CONTROL_OFS, 32'h1);
    wr(tpu_pkg::COMMAND_OFS, 32'h1);
    repeat (8) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, a);
    chk(32'h0, a);
    wr(tpu_pkg::TRIGGER_SELECT_OFS, 32'h21000);
    pulse(0);
    pulse(2);
    wr(tpu_pkg::BLOCK_CONTROL_OFS, 32'h0);
    rd(tpu_pkg::COUNT_OFS, a);
    repeat (20) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, b);
    chk(a, b);
    $display("test up done");
  endtask
  task t_capture();
    wr(tpu_pkg::BLOCK_CONTROL_OFS, 32'h1);
    wr(tpu_pkg::COMMAND_OFS, 32'h4);
    rd(tpu_pkg::COUNT_OFS, a);
    repeat (20) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, b);
    chk(a, b);
    pin();
    rd(tpu_pkg::COMPARE_OFS, b);
    chk(a, b);
    wr(tpu_pkg::COMMAND_OFS, 32'h2);
    repeat (3) @(posedge mclk);
    wr(tpu_pkg::COMMAND_OFS, 32'h4);
    rd(tpu_pkg::COUNT_OFS, b);
    chk(1, b !== a);
    pin();
    rd(tpu_pkg::COMPARE_OFS, c);
    chk(b, c);
    rd(tpu_pkg::COMPARE_BUF_OFS, c);
    chk(a, c);
    $display("test capture done");
  endtask
  // Kill on stop and buffer swap on capture in PWM mode
  task t_pwm();
    wr(tpu_pkg::COUNTER_CONTROL_OFS, 32'h4000000);
    wr(tpu_pkg::COMPARE_BUF_OFS, 32'h9);
    wr(tpu_pkg::COMMAND_OFS, 32'h4);
    repeat (2) @(posedge mclk);
    chk(32'h1, kill);
    wr(tpu_pkg::COMMAND_OFS, 32'h10);
    rd(tpu_pkg::COMPARE_OFS, a);
    chk(32'h9, a);
    rd(tpu_pkg::PERIOD_OFS, a);
    chk(32'hFFFF, a);
    wr(tpu_pkg::COMMAND_OFS, 32'h2);
    repeat (2) @(posedge mclk);
    chk(32'h0, kill);
    $display("test pwm done");
  endtask
  // Divide by 4: forty clocks hold exactly ten counter ticks
  task t_prescale();
    wr(tpu_pkg::COUNTER_CONTROL_OFS, 32'h200);
    wr(tpu_pkg::COMMAND_OFS, 32'h1);
    repeat (8) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, a);
    repeat (37) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, b);
    chk(32'hA, b - a);
    $display("test prescale done");
  endtask
  task t_down();
    wr(tpu_pkg::TRIGGER_SELECT_OFS, 32'h0);
    wr(tpu_pkg::COUNTER_CONTROL_OFS, 32'h10000);
    wr(tpu_pkg::COMMAND_OFS, 32'h1);
    repeat (8) @(posedge mclk);
    rd(tpu_pkg::COUNT_OFS, a);
    chk(32'h3, a);
    wr(tpu_pkg::TRIGGER_SELECT_OFS, 32'h1000);
    pulse(1);
    $display("test down done");
  endtask
  // ==========================================================
  // Verdict and end of run
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_up();
    t_capture();
    t_down();
    t_pwm();
    t_prescale();
    wrap_up();
  end
endmodule // tpu_core_tb
`default_nettype wire
